// ---- dv/swe_bus_model.sv ----
`timescale 1ns/1ps
// ****
// Bus drain model
// ****
// Keeps a transfer outstanding for three cycles after the core suspends.
module swe_bus_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic suspended_in,
	output logic bus_busy_out
);
	logic [1:0] drain_q; // Cycles of transfer left.
	logic susp_q; // Suspension seen last cycle.
	// Starts a drain on each entry to suspension.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			drain_q <= 2'h0;
			susp_q <= 1'b0;
		end else begin
			susp_q <= suspended_in;
			if (suspended_in && !susp_q) drain_q <= 2'h3;
			else if (drain_q != 2'h0) drain_q <= drain_q - 2'h1;
		end
	end
	assign bus_busy_out = (drain_q != 2'h0);
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
// ****
// Sleep and wake bench
// ****
module testbench;
	logic clk_in = 1'b0, rst_in = 1'b1;
	logic wait_for_event_instr = 1'b0, wait_for_interrupt_instr = 1'b0, send_event_instr = 1'b0, ret = 1'b0, slx = 1'b0, pend = 1'b0;
	logic pen = 1'b0, pre = 1'b0, grp = 1'b0, pm = 1'b0, dbg = 1'b0, den = 1'b0, imp = 1'b0;
	logic [3:0] sall = 4'h0, seo;
	logic done, susp, idle, lat, busy;
	logic [31:0] seed = 32'h9C87; // Random state.
	int fail_count = 0, n_tests = 0;
	swe_sleep_wake u_dut (.clk_in(clk_in), .rst_in(rst_in), .wait_for_event_instr_in(wait_for_event_instr),
		.wait_for_interrupt_instr_in(wait_for_interrupt_instr), .send_event_instr_in(send_event_instr), .send_event_all_in(sall),
		.exc_return_in(ret), .sleep_after_handler_exit_in(slx), .exc_new_pending_in(pend),
		.pend_as_wake_enable_in(pen), .exc_preempts_unmasked_in(pre),
		.exc_group_above_exec_in(grp), .priority_mask_bit_in(pm), .debug_event_in(dbg),
		.debug_enable_in(den), .impl_wake_in(imp), .bus_busy_in(busy), .send_event_out(seo),
		.instr_done_out(done), .suspended_out(susp), .bus_idle_out(idle),
		.event_latched_out(lat));
	swe_bus_model u_bus (.clk_in(clk_in), .rst_in(rst_in), .suspended_in(susp),
		.bus_busy_out(busy));
	// Makes the 100 ns clock.
	initial forever #50 clk_in = ~clk_in;
	// Steps the random generator.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Tells whether a source should end the wait.
	function automatic logic wake(input logic w, input int s, input logic e);
		case (s)
			0: return !w;
			1: return !w & e;
			2, 3: return e;
			default: return w;
		endcase
	endfunction
	// Compares one bit.
	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	// Compares a send-event vector.
	task automatic chkv(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	// Drives one wake source with its enable.
	task automatic src(input int s, input logic v, input logic e);
		case (s)
			0: sall <= {2'h0, v, 1'b0};
			1: begin pend <= v; pen <= e; end
			2: begin pre <= v; pm <= !e; end
			3: begin dbg <= v; den <= e; end
			4: begin pre <= v; grp <= v; pm <= 1'b1; end
			default: imp <= v;
		endcase
	endtask
	// Pulses reset and checks the quiet state.
	task automatic do_rst();
		@(posedge clk_in) rst_in <= 1'b1;
		@(posedge clk_in) rst_in <= 1'b0;
		#1 chk(lat, 1'b0);
		chkv(seo, 4'h0);
	endtask
	// Runs one wait with one source and its enable.
	task automatic trial(input logic w, input int s, input logic e);
		logic x;
		x = wake(w, s, e);
		do_rst();
		@(posedge clk_in) begin wait_for_interrupt_instr <= w; wait_for_event_instr <= !w; end
		@(posedge clk_in) begin wait_for_interrupt_instr <= 1'b0; wait_for_event_instr <= 1'b0; end
		#1 chk(susp, 1'b1);
		@(posedge clk_in) src(s, 1'b1, e);
		#1 chk(done, x);
		chk(idle, 1'b0);
		@(posedge clk_in) src(s, 1'b0, e);
		if (!x) src(w ? 5 : 0, 1'b1, e);
		#1 chk(done, !x);
		chk(susp, !x);
		@(posedge clk_in) src(w ? 5 : 0, 1'b0, e);
		#1 chk(susp, 1'b0);
		if (!w) begin
			chk(lat, 1'b1);
			@(posedge clk_in) wait_for_event_instr <= 1'b1;
			#1 chk(done, 1'b1);
			@(posedge clk_in) wait_for_event_instr <= 1'b0;
			#1 chk(lat, 1'b0);
		end
	endtask
	// Prints the verdict and stops.
	task automatic wrap_up();
		if (fail_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (4000) @(posedge clk_in);
		fail_count++;
		wrap_up();
	end
	// Main sequence: directed cases, full table, then random trials.
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in) send_event_instr <= 1'b1;
		@(posedge clk_in) send_event_instr <= 1'b0;
		#1 chkv(seo, 4'hF);
		chk(lat, 1'b1);
		@(posedge clk_in) begin wait_for_event_instr <= 1'b1; sall <= 4'h2; end
		#1 chk(done, 1'b1);
		@(posedge clk_in) begin wait_for_event_instr <= 1'b0; sall <= 4'h0; end
		#1 chk(lat, 1'b1);
		chkv(seo, 4'h0);
		do_rst();
		@(posedge clk_in) begin ret <= 1'b1; slx <= 1'b1; end
		@(posedge clk_in) begin ret <= 1'b0; slx <= 1'b0; imp <= 1'b1; end
		#1 chk(lat, 1'b1);
		chk(susp, 1'b1);
		@(posedge clk_in) imp <= 1'b0;
		#1 chk(susp, 1'b0);
		@(posedge clk_in) wait_for_interrupt_instr <= 1'b1;
		@(posedge clk_in) wait_for_interrupt_instr <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1 chk(idle, 1'b1);
		@(posedge clk_in) imp <= 1'b1;
		#1 chk(done, 1'b1);
		@(posedge clk_in) imp <= 1'b0;
		#1 chk(susp, 1'b0);
		for (int k = 0; k < 24; k++) trial(k[0], k / 4, k[1]);
		repeat (16) begin
			seed = lfsr(seed);
			trial(seed[0], int'(seed[7:4]) % 6, seed[1]);
		end
		wrap_up();
	end
endmodule

// ---- shared/swe_cfg.svh ----
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH
// Event latch value after reset.
`define SWE_LATCH_RST 1'b0
// Nonzero when resuming from an event wait also clears the latch.
`define SWE_RESUME_CLEARS 1'b0
// Default number of processors sharing the send-event wire.
`define SWE_NUM_PROC 4
`endif

// ---- shared/swe_pkg.sv ----
package swe_pkg;
	// Sleep sequencer states, one-hot.
	typedef enum logic [3:0] {
		SWE_RUN = 4'h1,
		SWE_EVT_WAIT = 4'h2,
		SWE_INT_WAIT = 4'h4,
		SWE_EXIT_WAIT = 4'h8
	} swe_state_type;
endpackage

// ---- src/swe_sleep_wake.sv ----
`timescale 1ns/1ps
`include "swe_cfg.svh"
// How it works
// - Other processors' send-event wakes event waits.
// - Pend-as-wake makes new pending exceptions wake.
// - Exception preempting all active ones wakes.
// - Debug event wakes only with debug enabled.
// - One event latch bit per processor.
// - Reset clears the event latch.
// - Wake events and exception returns set latch.
// - Event wait with latch set: clear, complete.
// - Software has no path to the latch.
// - Send-event signals every processor, sets latches.
// - Both instructions run at any privilege level.
// - Event wait with latch clear suspends until wake.
// - Early events are captured and collapse together.
// - Resume-clears-latch choice is fixed, parameterised.
// - Interrupt wait suspends until wake or reset.
// - Wake on preemption as if mask were 0.
// - Mask set: wake only above execution priority.
// - Debug wakes interrupt wait; extra source allowed.
// - Interrupt wait wakes counted only after issue.
// - Interrupt wait completes on detected wake event.
// - Report idle bus to power controller when waiting.
// - Pend-as-wake counts masked interrupts too.
// - Sleep-on-exit uses interrupt wait wake set.
module swe_sleep_wake #(
	parameter int NUM_PROC = `SWE_NUM_PROC,
	parameter int PROC_ID = 0,
	parameter bit RESUME_CLEARS = `SWE_RESUME_CLEARS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wait_for_event_instr_in,
	input wire logic wait_for_interrupt_instr_in,
	input wire logic send_event_instr_in,
	input wire logic [NUM_PROC-1:0] send_event_all_in,
	input wire logic exc_return_in,
	input wire logic sleep_after_handler_exit_in,
	input wire logic exc_new_pending_in,
	input wire logic pend_as_wake_enable_in,
	input wire logic exc_preempts_unmasked_in,
	input wire logic exc_group_above_exec_in,
	input wire logic priority_mask_bit_in,
	input wire logic debug_event_in,
	input wire logic debug_enable_in,
	input wire logic impl_wake_in,
	input wire logic bus_busy_in,
	output logic [NUM_PROC-1:0] send_event_out,
	output logic instr_done_out,
	output logic suspended_out,
	output logic bus_idle_out,
	output logic event_latched_out
);
	import swe_pkg::*;

	// ****************************************
	// Wake-up event decode
	// ****************************************

	logic evt_wake; // Event-wait wake source this cycle.
	logic int_wake; // Interrupt-wait wake source this cycle.
	logic other_sev; // Send-event seen from another processor.
	logic [NUM_PROC-1:0] others_mask; // All processors but this one.
	logic wait_entry; // Event wait instruction issued from run.
	logic latch_clear; // Latch consumed this cycle.
	logic resume_consume; // Wake swallowed by a resume that clears the latch.
	swe_state_type state_q;
	swe_state_type state_d;
	logic latch_q; // The event latch.
	logic latch_d; // Next latch value.

	// Builds the mask of every other processor.
	always_comb begin
		others_mask = '1;
		others_mask[PROC_ID] = 1'b0;
	end

	// Only send-events from other processors count as wake sources.
	assign other_sev = |(send_event_all_in & others_mask);

	// Event wait wake sources; pending changes count even when masked.
	assign evt_wake = other_sev |
		(pend_as_wake_enable_in & exc_new_pending_in) |
		(exc_preempts_unmasked_in & ~priority_mask_bit_in) |
		(debug_event_in & debug_enable_in);

	// Interrupt wait wake sources; the mask only narrows the priority test.
	assign int_wake = (priority_mask_bit_in ? exc_group_above_exec_in
		: exc_preempts_unmasked_in) |
		(debug_event_in & debug_enable_in) |
		impl_wake_in;

	// ****************************************
	// Send-event broadcast
	// ****************************************

	// Pulses every processor, this one included, for one cycle.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			send_event_out <= '0;
		end else begin
			send_event_out <= {NUM_PROC{send_event_instr_in}};
		end
	end

	// ****************************************
	// Event latch
	// ****************************************

	// An event wait is only taken while the sequencer runs.
	assign wait_entry = (state_q == SWE_RUN) & wait_for_event_instr_in;

	// When resume clears the latch, the wake that ends the wait is the one consumed.
	// Without this, the same wake would set the latch again and the option would be void.
	assign resume_consume = RESUME_CLEARS & (state_q == SWE_EVT_WAIT) & evt_wake;

	// The latch is consumed by an event wait issued with it set, or optionally on resume.
	assign latch_clear = (wait_entry & latch_q) |
		resume_consume;

	// Sets win over clears so a coincident event is kept.
	// The wait-entry clear and a resume never fall in one cycle, as they need different states.
	always_comb begin
		latch_d = latch_q;
		if (latch_clear) begin
			latch_d = 1'b0;
		end
		if ((evt_wake & ~resume_consume) | exc_return_in | send_event_instr_in) begin
			latch_d = 1'b1;
		end
	end

	// Single latch bit with no software access port.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch_q <= `SWE_LATCH_RST;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ****************************************
	// Sleep sequencer
	// ****************************************

	// Chooses run, event wait, interrupt wait or sleep after handler exit.
	always_comb begin
		state_d = state_q;
		instr_done_out = 1'b0;
		case (state_q)
			SWE_RUN: begin
				if (wait_for_event_instr_in) begin
					// A set latch lets the instruction finish at once.
					if (latch_q) begin
						instr_done_out = 1'b1;
					end else begin
						state_d = SWE_EVT_WAIT;
					end
				end else if (wait_for_interrupt_instr_in) begin
					// Earlier wake sources are not remembered here.
					state_d = SWE_INT_WAIT;
				end else if (exc_return_in & sleep_after_handler_exit_in) begin
					state_d = SWE_EXIT_WAIT;
				end
			end
			SWE_EVT_WAIT: begin
				// Any event-wait wake source ends the suspension.
				if (evt_wake) begin
					instr_done_out = 1'b1;
					state_d = SWE_RUN;
				end
			end
			SWE_INT_WAIT: begin
				// Wakes counted only from the cycle after issue.
				if (int_wake) begin
					instr_done_out = 1'b1;
					state_d = SWE_RUN;
				end
			end
			SWE_EXIT_WAIT: begin
				// Same wake set as an interrupt wait.
				if (int_wake) begin
					state_d = SWE_RUN;
				end
			end
			default: begin
				state_d = SWE_RUN;
			end
		endcase
	end

	// Holds the sequencer state.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= SWE_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************

	assign suspended_out = (state_q != SWE_RUN);
	assign event_latched_out = latch_q;
	// Idle report for the power controller while asleep and quiet.
	assign bus_idle_out = suspended_out & ~bus_busy_in;

	// ****************************************
	// Checks
	// ****************************************

	AST_OTHER_SEV_SETS: assert property (@(posedge clk_in) disable iff (rst_in)
		other_sev |=> latch_q) else $error("Other send-event did not set latch.");
	AST_PEND_WAKE: assert property (@(posedge clk_in) disable iff (rst_in)
		(pend_as_wake_enable_in & exc_new_pending_in) |=> latch_q)
		else $error("Pending change did not set latch.");
	AST_DEBUG_GATED: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_EVT_WAIT) & ~evt_wake & debug_event_in |-> ~debug_enable_in)
		else $error("Enabled debug event missed.");
	AST_RET_SETS: assert property (@(posedge clk_in) disable iff (rst_in)
		exc_return_in |=> latch_q) else $error("Exception return did not set latch.");
	AST_SET_FAST: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_RUN) & wait_for_event_instr_in & latch_q & ~evt_wake & ~exc_return_in
		& ~send_event_instr_in |-> instr_done_out ##1 (~latch_q && state_q == SWE_RUN))
		else $error("Set latch did not complete event wait at once.");
	AST_SEV_ALL: assert property (@(posedge clk_in) disable iff (rst_in)
		send_event_instr_in |=> (&send_event_out) && latch_q)
		else $error("Send-event not broadcast.");
	AST_EVT_SUSPEND: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_RUN) & wait_for_event_instr_in & ~latch_q |=> suspended_out)
		else $error("Event wait with clear latch did not suspend.");
	AST_INT_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_INT_WAIT) & int_wake |-> instr_done_out ##1 ~suspended_out)
		else $error("Interrupt wait did not complete on wake.");
	AST_MASKED_PRIO: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_INT_WAIT) & priority_mask_bit_in & ~exc_group_above_exec_in
		& ~debug_event_in & ~impl_wake_in |=> suspended_out)
		else $error("Masked low-priority exception woke interrupt wait.");
	AST_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
		bus_idle_out |-> suspended_out && !bus_busy_in) else $error("Idle reported while active.");
	AST_SET_WINS: assert property (@(posedge clk_in) disable iff (rst_in)
		latch_clear & evt_wake |=> latch_q) else $error("Wake lost against clear.");

	// ****************************************
	// Further checks
	// ****************************************

	// The checks below guard the sequencer entries and exits, the resume latch choice and the broadcast pulse.
	// They look only at this block's own ports and state, so they also hold in a system
	// where several copies share one send-event bus.

	// An unmasked preemption must end an event wait in the same cycle.
	AST_PREEMPT_WAKE: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_EVT_WAIT) & exc_preempts_unmasked_in & ~priority_mask_bit_in
		|-> instr_done_out) else $error("Preempting exception did not end event wait.");

	// An event wait that sees a wake completes now and runs next cycle.
	AST_EVT_WAKE_RUN: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_EVT_WAIT) & evt_wake |-> instr_done_out ##1 ~suspended_out)
		else $error("Event wait did not complete on wake.");

	// The resume choice decides what the latch holds after a wake ends the wait.
	AST_RESUME_CHOICE: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_EVT_WAIT) & evt_wake & ~exc_return_in & ~send_event_instr_in
		|=> latch_q == !RESUME_CLEARS) else $error("Resume latch choice not kept.");

	// An interrupt wait issued without an event wait always suspends, whatever wake sources stood before it.
	AST_INT_SUSPEND: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_RUN) & wait_for_interrupt_instr_in & ~wait_for_event_instr_in
		|=> suspended_out) else $error("Interrupt wait did not suspend.");

	// Sleep after handler exit leaves on the interrupt wait wake set.
	AST_EXIT_WAKE: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_EXIT_WAIT) & int_wake |=> ~suspended_out)
		else $error("Sleep after exit did not wake.");

	// The broadcast is a single-cycle pulse and stays low without a send-event.
	AST_SEV_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
		~send_event_instr_in |=> send_event_out == '0)
		else $error("Send-event pulse outlived its instruction.");

	// A core in an interrupt wait must not complete it without a wake source.
	AST_NO_SPURIOUS_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_q == SWE_INT_WAIT) & ~int_wake |-> ~instr_done_out)
		else $error("Interrupt wait completed without a wake.");
endmodule
